// *** design/dpe_encoder.sv ***
`timescale 1ns/1ps
// Summary of operation
// - each channel sends exactly one of two candidate characters per symbol
// - running ones/zeros tally picks the low-transition, dc-balanced candidate
// - active video: bits 23:16 red lane, 15:8 green lane, 7:0 blue lane
// - blanking: red carries ctrl bit 1, green ctrl bit 0, blue hsync/vsync
// - the third control bit is always encoded as zero
// - the two general control bits are carried across during blanking
// - differential clock mode latches on the crossing of the two phases
// - pixel input arrives over 12 or 24 data lines by bus width mode
// - 12-bit mode captures a half pixel on every input clock edge
// - 24-bit mode captures once per period, rising if edge select is 1
// - latch shift enable moves the latch instant by the 3-bit amount
// - configuration comes from straps at reset, serial settings may override
// - receiver detection always; hot-plug detection only with serial config on
// - bus width select 0 is 12-bit dual edge, 1 is 24-bit single edge
// - in 12-bit mode edge select picks the primary edge, 1 rising
// - 12-bit halves: first {g[3:0],b}, second {r,g[7:4]}
// - serial config on takes width, clock style, edge from mode register
module dpe_encoder (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        pixel_in_clock_p,
    input  wire logic        pixel_in_clock_n,
    input  wire logic [23:0] pixel_data,
    input  wire logic        active_video_flag,
    input  wire logic        hsync_in,
    input  wire logic        vsync_in,
    input  wire logic [2:0]  blanking_ctrl_bits,
    input  wire logic        strap_bus_width_select,
    input  wire logic        strap_clock_style_select,
    input  wire logic        strap_edge_select,
    input  wire logic        strap_latch_shift_enable,
    input  wire logic [2:0]  strap_latch_shift_amount,
    input  wire logic        serial_config_enable,
    input  wire logic [2:0]  interface_mode_reg,
    input  wire logic        cfg_latch_shift_enable,
    input  wire logic [2:0]  cfg_latch_shift_amount,
    input  wire logic        receiver_sense,
    input  wire logic        hot_plug_sense,
    output logic [9:0]       red_lane,
    output logic [9:0]       green_lane,
    output logic [9:0]       blue_lane,
    output logic             lane_word_valid,
    output logic             pixel_clock_out,
    output logic             monitor_detected,
    output logic             hot_plug_detected
);
    typedef logic [dpe_pkg::BUNDLE_W-1:0] dpe_bundle_t;

    typedef struct packed {
        logic                                   ref_q;
        dpe_bundle_t [dpe_pkg::DELAY_DEPTH-1:0] line_q;
        dpe_bundle_t                            half_q;
        logic                                   half_pend_q;
        logic                                   strap_width_q;
        logic                                   strap_style_q;
        logic                                   strap_edge_q;
        logic                                   strap_shen_q;
        logic [2:0]                             strap_amt_q;
        logic [2:0][4:0]                        disp_q;
        logic [2:0][9:0]                        sym_q;
        logic                                   valid_q;
        logic                                   fwd_clk_q;
        logic                                   mon_q;
        logic                                   hpd_q;
    } dpe_state_t;

    dpe_state_t s_q;
    dpe_state_t s_d;

    function automatic logic [3:0] dpe_ones(input logic [7:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction

    // returns {new tally, character}
    function automatic logic [14:0] dpe_tm_encode(input logic [7:0] d,
                                                  input logic [4:0] cnt);
        logic [8:0]        qm;
        logic [3:0]        n1;
        logic              use_xnor;
        logic signed [4:0] c;
        logic signed [4:0] diff;
        logic [9:0]        q;
        n1 = dpe_ones(d);
        use_xnor = (n1 > 4'h4) || (n1 == 4'h4 && !d[0]);
        qm[0] = d[0];
        for (int i = 1; i < 8; i++) begin
            qm[i] = use_xnor ? ~(qm[i-1] ^ d[i]) : (qm[i-1] ^ d[i]);
        end
        qm[8] = !use_xnor;
        c = $signed(cnt);
        // ones minus zeros of the 8 payload bits
        diff = $signed({1'b0, dpe_ones(qm[7:0])}) * 5'sd2 - 5'sd8;
        if (c == 5'sd0 || diff == 5'sd0) begin
            q = {~qm[8], qm[8], qm[8] ? qm[7:0] : ~qm[7:0]};
            c = qm[8] ? c + diff : c - diff;
        end else if ((c > 5'sd0 && diff > 5'sd0) || (c < 5'sd0 && diff < 5'sd0)) begin
            q = {1'b1, qm[8], ~qm[7:0]};
            c = c + (qm[8] ? 5'sd2 : 5'sd0) - diff;
        end else begin
            q = {1'b0, qm[8], qm[7:0]};
            c = c - (qm[8] ? 5'sd0 : 5'sd2) + diff;
        end
        return {c, q};
    endfunction

    function automatic logic [9:0] dpe_ctrl_sym(input logic [1:0] c);
        logic [9:0] q;
        unique case (c)
            2'b00: q = dpe_pkg::CTRL_SYM_00;
            2'b01: q = dpe_pkg::CTRL_SYM_01;
            2'b10: q = dpe_pkg::CTRL_SYM_10;
            2'b11: q = dpe_pkg::CTRL_SYM_11;
        endcase
        return q;
    endfunction

    logic        width_sel;
    logic        style_sel;
    logic        edge_sel;
    logic        shift_en;
    logic [2:0]  shift_amt;
    logic        ref_now;
    logic        rise;
    logic        fall;
    logic        prim;
    logic        sec;
    logic [3:0]  tap;
    dpe_bundle_t latched;
    dpe_bundle_t pix;
    logic        pix_ok;
    logic [14:0] enc_r;
    logic [14:0] enc_g;
    logic [14:0] enc_b;

    always_comb begin
        s_d = s_q;
        // serial config overrides the captured straps
        width_sel = serial_config_enable ? interface_mode_reg[dpe_pkg::M_BUS_WIDTH]
                                         : s_q.strap_width_q;
        style_sel = serial_config_enable ? interface_mode_reg[dpe_pkg::M_CLOCK_STYLE]
                                         : s_q.strap_style_q;
        edge_sel  = serial_config_enable ? interface_mode_reg[dpe_pkg::M_EDGE]
                                         : s_q.strap_edge_q;
        shift_en  = serial_config_enable ? cfg_latch_shift_enable : s_q.strap_shen_q;
        shift_amt = serial_config_enable ? cfg_latch_shift_amount : s_q.strap_amt_q;

        // a tie between the phases keeps the last level so noise cannot fake an edge
        // single-ended only where the style bit differs from the width bit
        if (style_sel != width_sel) begin
            ref_now = pixel_in_clock_p;
        end else if (pixel_in_clock_p != pixel_in_clock_n) begin
            ref_now = pixel_in_clock_p;
        end else begin
            ref_now = s_q.ref_q;
        end
        rise = ref_now && !s_q.ref_q;
        fall = !ref_now && s_q.ref_q;
        prim = edge_sel ? rise : fall;
        sec  = edge_sel ? fall : rise;

        s_d.ref_q = ref_now;
        s_d.line_q[0] = {active_video_flag, hsync_in, vsync_in,
                         blanking_ctrl_bits[1], blanking_ctrl_bits[0], pixel_data};
        for (int i = 1; i < dpe_pkg::DELAY_DEPTH; i++) begin
            s_d.line_q[i] = s_q.line_q[i-1];
        end
        // older tap latches earlier: amount 0 is eight steps before the edge
        if (shift_en) begin
            tap = 4'(dpe_pkg::SHIFT_SPAN - int'(shift_amt)) * 4'(dpe_pkg::STEP_CYC);
        end else begin
            tap = 4'({1'b0, dpe_pkg::SHIFT_CENTRE}) * 4'(dpe_pkg::STEP_CYC);
        end
        latched = s_q.line_q[tap];

        pix = latched;
        pix_ok = 1'b0;
        if (width_sel) begin
            pix_ok = prim;
        end else begin
            if (prim) begin
                s_d.half_q = latched;
                s_d.half_pend_q = 1'b1;
            end else if (sec && s_q.half_pend_q) begin
                s_d.half_pend_q = 1'b0;
                pix_ok = 1'b1;
                pix[23:16] = latched[11:4];
                pix[15:8]  = {latched[3:0], s_q.half_q[11:8]};
                pix[7:0]   = s_q.half_q[7:0];
            end
        end

        enc_r = dpe_tm_encode(pix[23:16], s_q.disp_q[2]);
        enc_g = dpe_tm_encode(pix[15:8], s_q.disp_q[1]);
        enc_b = dpe_tm_encode(pix[7:0], s_q.disp_q[0]);
        s_d.valid_q = pix_ok;
        if (pix_ok) begin
            if (pix[dpe_pkg::B_DE]) begin
                s_d.sym_q[2] = enc_r[9:0];
                s_d.sym_q[1] = enc_g[9:0];
                s_d.sym_q[0] = enc_b[9:0];
                s_d.disp_q[2] = enc_r[14:10];
                s_d.disp_q[1] = enc_g[14:10];
                s_d.disp_q[0] = enc_b[14:10];
            end else begin
                // third control bit forced low, whatever is on its pin
                s_d.sym_q[2] = dpe_ctrl_sym({1'b0, pix[dpe_pkg::B_C2]});
                s_d.sym_q[1] = dpe_ctrl_sym({1'b0, pix[dpe_pkg::B_C1]});
                s_d.sym_q[0] = dpe_ctrl_sym({pix[dpe_pkg::B_VS], pix[dpe_pkg::B_HS]});
                s_d.disp_q = {3{dpe_pkg::DISP_RESET}};
            end
        end
        // clock forwarded at pixel rate, one word per lane per period
        s_d.fwd_clk_q = ref_now;
        s_d.mon_q = receiver_sense;
        s_d.hpd_q = serial_config_enable && hot_plug_sense;

        if (!rstn) begin
            s_d = '0;
            s_d.strap_width_q = strap_bus_width_select;
            s_d.strap_style_q = strap_clock_style_select;
            s_d.strap_edge_q  = strap_edge_select;
            s_d.strap_shen_q  = strap_latch_shift_enable;
            s_d.strap_amt_q   = strap_latch_shift_amount;
        end
    end

    always_ff @(posedge clk_sys) begin
        s_q <= s_d;
    end

    assign red_lane          = s_q.sym_q[2];
    assign green_lane        = s_q.sym_q[1];
    assign blue_lane         = s_q.sym_q[0];
    assign lane_word_valid   = s_q.valid_q;
    assign pixel_clock_out   = s_q.fwd_clk_q;
    assign monitor_detected  = s_q.mon_q;
    assign hot_plug_detected = s_q.hpd_q;
endmodule

// *** design/dpe_pkg.sv ***
package dpe_pkg;
    localparam int          CLK_PERIOD_PS  = 5000;
    localparam int          T_STEP_PS      = 350;
    // a trim step is far below one system cycle, so one step becomes one whole cycle
    localparam int          STEP_CYC       = (T_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          SHIFT_SPAN     = 8;
    localparam int          DELAY_DEPTH    = SHIFT_SPAN * STEP_CYC + 1;
    localparam logic [2:0]  SHIFT_CENTRE   = 3'h4;
    localparam int          PIX_W          = 24;
    localparam int          HALF_W         = 12;
    localparam int          SYM_W          = 10;
    localparam int          BUNDLE_W       = PIX_W + 5;
    // bundle field positions
    localparam int          B_DE           = 28;
    localparam int          B_HS           = 27;
    localparam int          B_VS           = 26;
    localparam int          B_C2           = 25;
    localparam int          B_C1           = 24;
    // interface_mode_reg field positions
    localparam int          M_BUS_WIDTH    = 0;
    localparam int          M_CLOCK_STYLE  = 1;
    localparam int          M_EDGE         = 2;
    // control characters, indexed by {bit1, bit0}
    localparam logic [9:0]  CTRL_SYM_00    = 10'h354;
    localparam logic [9:0]  CTRL_SYM_01    = 10'h0ab;
    localparam logic [9:0]  CTRL_SYM_10    = 10'h154;
    localparam logic [9:0]  CTRL_SYM_11    = 10'h2ab;
    localparam logic [4:0]  DISP_RESET     = 5'h00;
endpackage

// *** verification/dpe_encoder_props.sv ***
`timescale 1ns/1ps
module dpe_props (
    input wire logic       clk_sys,
    input wire logic       rstn,
    input wire logic       pixel_in_clock_p,
    input wire logic       serial_config_enable,
    input wire logic       receiver_sense,
    input wire logic       hot_plug_sense,
    input wire logic [9:0] red_lane,
    input wire logic [9:0] green_lane,
    input wire logic [9:0] blue_lane,
    input wire logic       lane_word_valid,
    input wire logic       pixel_clock_out,
    input wire logic       monitor_detected,
    input wire logic       hot_plug_detected
);
    logic [3:0] hist_q;
    logic       moved;
    // a source edge needs a few cycles to be seen, so look back over a short history
    always_ff @(posedge clk_sys) hist_q <= {hist_q[2:0], pixel_in_clock_p};
    assign moved = {hist_q, pixel_in_clock_p} != 5'h00 && {hist_q, pixel_in_clock_p} != 5'h1f;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence s_quiet3; !lane_word_valid [*3]; endsequence
    property p_pulse; lane_word_valid |=> s_quiet3; endproperty
    a_pulse: assert property (p_pulse) else $error("word valid not a lone pulse");
    property p_cause; lane_word_valid |-> moved; endproperty
    a_cause: assert property (p_cause) else $error("word without source edge");
    property p_clk; $changed(pixel_clock_out) && $past(rstn, 4) |-> moved; endproperty
    a_clk: assert property (p_clk) else $error("clock out moved alone");
    property p_hold;
        !lane_word_valid |-> $stable(red_lane) && $stable(green_lane) && $stable(blue_lane);
    endproperty
    a_hold: assert property (p_hold) else $error("lane changed without valid");
    property p_first; $rose(rstn) |-> !lane_word_valid && green_lane == 10'h000; endproperty
    a_first: assert property (p_first) else $error("output busy after reset");
    property p_mon; $past(rstn) |-> monitor_detected == $past(receiver_sense); endproperty
    a_mon: assert property (p_mon) else $error("receiver detect wrong");
    property p_hot;
        $past(rstn) && $past(hot_plug_sense) && $past(serial_config_enable) |-> hot_plug_detected;
    endproperty
    a_hot: assert property (p_hot) else $error("hot plug missed");
    property p_hot_off; $past(rstn) && !$past(serial_config_enable) |-> !hot_plug_detected;
    endproperty
    a_hot_off: assert property (p_hot_off) else $error("hot plug without serial");
endmodule
bind dpe_encoder dpe_props u_props (.clk_sys(clk_sys), .rstn(rstn),
    .pixel_in_clock_p(pixel_in_clock_p), .serial_config_enable(serial_config_enable),
    .receiver_sense(receiver_sense), .hot_plug_sense(hot_plug_sense), .red_lane(red_lane),
    .green_lane(green_lane), .blue_lane(blue_lane), .lane_word_valid(lane_word_valid),
    .pixel_clock_out(pixel_clock_out), .monitor_detected(monitor_detected),
    .hot_plug_detected(hot_plug_detected));

// *** verification/dpe_source.sv ***
`timescale 1ns/1ps
module dpe_source (
    input  wire logic        clk_sys,
    input  wire logic        run,
    input  wire logic        wide,
    input  wire logic        rise,
    input  wire logic [29:0] word,
    output logic             ld,
    output logic             clk_p,
    output logic             clk_n,
    output logic [23:0]      data,
    output logic [5:0]       side
);
    logic [4:0]  ph_q = 5'h00;
    logic [29:0] cur_q;
    logic        tog_q = 1'b0;
    logic        hi;
    logic        sec;
    // primary edge at phase 6, secondary at 18; data moves at 1 and 13, far from both
    assign ld = run && ph_q == 5'h00;
    assign hi = ph_q >= 5'h06 && ph_q < 5'h12;
    assign sec = ph_q == 5'h00 || ph_q > 5'h0c;
    assign clk_p = hi ~^ rise;
    assign clk_n = ~clk_p;
    assign side = cur_q[29:24];
    assign data = !run ? {24{tog_q}} : wide ? cur_q[23:0] : {{12{tog_q}}, sec ?
        {cur_q[23:16], cur_q[15:12]} : {cur_q[11:8], cur_q[7:0]}};
    always @(posedge clk_sys) begin
        tog_q <= ~tog_q;
        ph_q <= (!run || ph_q == 5'h17) ? 5'h00 : ph_q + 5'h01;
        if (!run || ph_q == 5'h00) cur_q <= word;
    end
endmodule

// *** verification/dpe_encoder_tb.sv ***
`timescale 1ns/1ps
module dpe_encoder_tb;
    logic        clk_sys = 1'b0, rstn = 1'b0, run = 1'b0, wide = 1'b1, rise = 1'b1;
    logic        ser = 1'b0, rx = 1'b0, hp = 1'b0, sh = 1'b0;
    logic [2:0]  strap = 3'h0, mode = 3'h0;
    logic [29:0] word = 30'h0, e;
    logic [23:0] data;
    logic [9:0]  red, grn, blu;
    logic [5:0]  side;
    logic        ld, cp, cn, vld, pco, mon, hpd;
    logic [29:0] exp_q[$];
    int          miscompares = 0, checked = 0, disp[3];
    always #2.5 clk_sys = ~clk_sys;
    dpe_source src (.clk_sys(clk_sys), .run(run), .wide(wide), .rise(rise), .word(word),
        .ld(ld), .clk_p(cp), .clk_n(cn), .data(data), .side(side));
    dpe_encoder dut (.clk_sys(clk_sys), .rstn(rstn), .pixel_in_clock_p(cp),
        .pixel_in_clock_n(cn), .pixel_data(data), .active_video_flag(side[5]),
        .hsync_in(side[4]), .vsync_in(side[3]), .blanking_ctrl_bits(side[2:0]),
        .strap_bus_width_select(strap[0]), .strap_clock_style_select(strap[1]),
        .strap_edge_select(strap[2]), .strap_latch_shift_enable(1'b0),
        .strap_latch_shift_amount(3'h0), .serial_config_enable(ser), .interface_mode_reg(mode),
        .cfg_latch_shift_enable(sh), .cfg_latch_shift_amount(3'h7), .receiver_sense(rx),
        .hot_plug_sense(hp), .red_lane(red), .green_lane(grn), .blue_lane(blu),
        .lane_word_valid(vld), .pixel_clock_out(pco), .monitor_detected(mon),
        .hot_plug_detected(hpd));
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // undo the xor/xnor chain, so no encoder copy is needed here
    function automatic logic [7:0] dec(input logic [9:0] s);
        logic [7:0] d, o;
        d = s[9] ? ~s[7:0] : s[7:0];
        o[0] = d[0];
        for (int i = 1; i < 8; i++) o[i] = d[i] ^ d[i-1] ^ ~s[8];
        return o;
    endfunction
    function automatic logic [9:0] csym(input logic [1:0] c);
        return c[1] ? (c[0] ? dpe_pkg::CTRL_SYM_11 : dpe_pkg::CTRL_SYM_10)
                    : (c[0] ? dpe_pkg::CTRL_SYM_01 : dpe_pkg::CTRL_SYM_00);
    endfunction
    always @(posedge clk_sys) begin
        if (vld === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (e[29]) begin
                chk(dec(red), e[23:16]);
                chk(dec(grn), e[15:8]);
                chk(dec(blu), e[7:0]);
                disp[0] += 2 * $countones(red) - 10;
                disp[1] += 2 * $countones(grn) - 10;
                disp[2] += 2 * $countones(blu) - 10;
                chk(disp[0] > 20 || disp[1] > 20 || disp[2] > 20, 0);
            end else begin
                chk(blu, csym({e[27], e[28]}));
                chk(grn, csym({1'b0, e[24]}));
                chk(red, csym({1'b0, e[25]}));
                disp = '{0, 0, 0};
            end
        end
    end
    task automatic restart(input logic w, input logic r, input logic s);
        run <= 1'b0;
        rstn <= 1'b0;
        ser <= s;
        sh <= s;
        strap <= s ? {~r, ~w, ~w} : {r, w, w};
        mode <= {r, w, w};
        wide <= w;
        rise <= r;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        exp_q.delete();
        disp = '{0, 0, 0};
    endtask
    // four all-ones pixels in a row force the tally to balance
    task automatic burst;
        logic [23:0] px[6] = '{24'h00ff80, 24'hffffff, 24'hffffff, 24'hffffff, 24'hffffff,
                               24'h123456};
        logic [29:0] w;
        int n;
        for (int i = 0; i < 10; i++) begin
            w = (i < 6) ? {6'h20, px[i]} : {1'b0, i[0], i[1], 1'b1, i[1], i[0], 24'h5a5a5a};
            word <= w;
            exp_q.push_back(w);
            run <= 1'b1;
            @(posedge clk_sys iff ld);
        end
        n = 0;
        while (exp_q.size() > 0 && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
        chk(32'(exp_q.size()), 0);
    endtask
    task automatic sc_wide_rise; restart(1'b1, 1'b1, 1'b0); burst(); endtask
    task automatic sc_wide_fall; restart(1'b1, 1'b0, 1'b0); burst(); endtask
    task automatic sc_half_rise; restart(1'b0, 1'b1, 1'b0); burst(); endtask
    task automatic sc_half_fall; restart(1'b0, 1'b0, 1'b0); burst(); endtask
    task automatic sc_serial; restart(1'b0, 1'b1, 1'b1); burst(); endtask
    task automatic sc_detect;
        rx <= 1'b1;
        hp <= 1'b1;
        ser <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(mon, 1);
        chk(hpd, 0);
        ser <= 1'b1;
        rx <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(hpd, 1);
        chk(mon, 0);
    endtask
    task automatic wrap_up;
        $display("compares %0d, miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #50000;
        miscompares++;
        wrap_up();
    end
    initial begin
        sc_wide_rise();
        sc_wide_fall();
        sc_half_rise();
        sc_half_fall();
        sc_serial();
        sc_detect();
        wrap_up();
    end
endmodule
